// ===== core/hsz_pkg.sv
// Package for the homing start and zero-set controller
package hsz_pkg;
    // Register byte offsets (word aligned)
    localparam logic [3:0] HSZ_OFF_CTRL = 4'h0;
    localparam logic [3:0] HSZ_OFF_TYPE = 4'h4;
    localparam logic [3:0] HSZ_OFF_ZOFF = 4'h8;
    localparam logic [3:0] HSZ_OFF_STAT = 4'hC;
    // Control register fields
    localparam int HSZ_CTRL_MODE_LSB = 0;
    localparam int HSZ_CTRL_BUSREQ_BIT = 4;
    localparam int HSZ_CTRL_CTLSTART_BIT = 5;
    localparam int HSZ_CTRL_TBLSEL_BIT = 6;
    localparam int HSZ_CTRL_TBLMODE_BIT = 7;
    localparam int HSZ_CTRL_ABSENC_BIT = 8;
    // Status register fields
    localparam int HSZ_STAT_REFD_BIT = 0;
    localparam int HSZ_STAT_BUSY_BIT = 1;
    // Reset values
    localparam logic [1:0] HSZ_MODE_RST = 2'h0;
    localparam logic signed [7:0] HSZ_TYPE_RST = 8'hFF;
    localparam logic signed [31:0] HSZ_ZOFF_RST = 32'h0000_0000;
    // Type selector range
    localparam logic signed [7:0] HSZ_TYPE_MIN = 8'hF9;
    localparam logic signed [7:0] HSZ_TYPE_MAX = 8'h23;
    localparam logic signed [7:0] HSZ_TYPE_SETPOS = 8'hF9;
    localparam logic signed [7:0] HSZ_TYPE_ABS = 8'hFB;
    // Start condition settings
    localparam logic [1:0] HSZ_START_OFF = 2'h0;
    localparam logic [1:0] HSZ_START_AUTO = 2'h1;
    localparam logic [1:0] HSZ_START_ON_FIRST_TABLE_SET = 2'h2;
    // Run states
    typedef enum logic [2:0] {
        HSZ_IDLE = 3'b001,
        HSZ_RUN = 3'b010,
        HSZ_LOAD = 3'b100
    } hsz_state_t;
endpackage

// ===== core/hsz_homing_start.sv
// Homing start decision and zero-set logic with an Avalon-MM register slave
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module hsz_homing_start
    import hsz_pkg::*;
#(
    parameter int POS_W = 32
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic input_homing_start_function,
    input wire logic seq_goto_ref,
    input wire logic lim_neg,
    input wire logic lim_pos,
    input wire logic ref_cam,
    input wire logic enc_index,
    input wire logic [POS_W-1:0] enc_abs_pos,
    input wire logic power_on,
    input wire logic move_done,
    output logic [POS_W-1:0] act_pos,
    output logic act_pos_load,
    output logic ferr_clear,
    output logic move_req,
    output logic referenced,
    output logic [3:0] ref_inputs
);

    // Position path is one bus word wide; other widths are refused
    if (POS_W != 32)
    begin : g_bad_width
        $error("hsz_homing_start: POS_W must be 32");
    end

    hsz_state_t state_r, state_nxt;
    logic [1:0] mode_r;
    logic bus_req_r, ctl_start_r, tbl_sel_r, tbl_mode_r, abs_enc_r;
    logic signed [7:0] type_r;
    logic signed [31:0] zoff_r;
    logic refd_r, ack_r, pwr_seen_r, wait_r, bus_run_r;
    logic [POS_W-1:0] pos_r;
    logic load_r, ferr_r, move_r;
    logic [1:0] hs_sync_r;
    logic hs_prev_r;
    logic [3:0] ref_sync1_r, ref_sync2_r;
    logic bus_prev_r, ctl_prev_r, tbl_prev_r, seq_prev_r;

    // Bus decode; every access answered after one wait cycle
    wire acc = (avs_read | avs_write) & ~ack_r;
    wire wr_ctrl = avs_write & ack_r & (avs_address == HSZ_OFF_CTRL);
    wire wr_type = avs_write & ack_r & (avs_address == HSZ_OFF_TYPE);
    wire wr_zoff = avs_write & ack_r & (avs_address == HSZ_OFF_ZOFF);
    wire signed [7:0] type_wd = avs_writedata[7:0];
    wire type_ok = (type_wd >= HSZ_TYPE_MIN) && (type_wd <= HSZ_TYPE_MAX);
    wire type_wr_ok = wr_type & avs_byteenable[0] & type_ok;
    wire zoff_wr = wr_zoff & (&avs_byteenable);
    wire cfg_change = (type_wr_ok & (type_wd != type_r))
        | (zoff_wr & (avs_writedata != zoff_r))
        | (wr_ctrl & avs_byteenable[0] & (avs_writedata[1:0] != mode_r));

    // Request sources and start qualifiers
    wire hs_rise = hs_sync_r[1] & ~hs_prev_r;
    wire seq_rise = seq_goto_ref & ~seq_prev_r;
    wire bus_rise = bus_req_r & ~bus_prev_r;
    wire ctl_rise = ctl_start_r & ~ctl_prev_r;
    wire tbl_rise = tbl_sel_r & ~tbl_prev_r;
    wire is_abs = (type_r == HSZ_TYPE_ABS);
    wire req_off = (mode_r == HSZ_START_OFF) & (hs_rise | seq_rise | bus_rise);
    wire req_auto = (mode_r == HSZ_START_AUTO) & ctl_rise & ~refd_r;
    wire req_tbl = (mode_r == HSZ_START_ON_FIRST_TABLE_SET) & tbl_mode_r & tbl_rise
        & ~refd_r;
    wire req_pwr = is_abs & ~pwr_seen_r;
    wire start = (state_r == HSZ_IDLE) & (req_off | req_auto | req_tbl | req_pwr);
    // Fieldbus bit back to 0 cuts a motion run that the bit itself started
    wire bus_abort = (state_r == HSZ_RUN) & bus_run_r & ~bus_req_r
        & (mode_r == HSZ_START_OFF);
    wire no_move = is_abs | abs_enc_r | (type_r == HSZ_TYPE_SETPOS);
    wire [POS_W-1:0] abs_sum = POS_W'(enc_abs_pos + zoff_r);

    // Run state machine
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            HSZ_IDLE:
            begin
                if (start)
                    state_nxt = no_move ? HSZ_LOAD : HSZ_RUN;
            end
            HSZ_RUN:
            begin
                if (bus_abort)
                    state_nxt = HSZ_IDLE;
                else if (move_done)
                    state_nxt = HSZ_LOAD;
            end
            HSZ_LOAD: state_nxt = HSZ_IDLE;
            default: state_nxt = HSZ_IDLE;
        endcase
    end

    // Register file and bus handshake
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            ack_r <= 1'b0;
            wait_r <= 1'b1;
            mode_r <= HSZ_MODE_RST;
            type_r <= HSZ_TYPE_RST;
            zoff_r <= HSZ_ZOFF_RST;
            {bus_req_r, ctl_start_r, tbl_sel_r, tbl_mode_r, abs_enc_r} <= 5'h00;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= acc;
            wait_r <= ~acc;
            if (wr_ctrl & avs_byteenable[0])
            begin
                mode_r <= avs_writedata[1:0];
                bus_req_r <= avs_writedata[HSZ_CTRL_BUSREQ_BIT];
                ctl_start_r <= avs_writedata[HSZ_CTRL_CTLSTART_BIT];
                tbl_sel_r <= avs_writedata[HSZ_CTRL_TBLSEL_BIT];
                tbl_mode_r <= avs_writedata[HSZ_CTRL_TBLMODE_BIT];
            end
            if (wr_ctrl & avs_byteenable[1])
                abs_enc_r <= avs_writedata[HSZ_CTRL_ABSENC_BIT];
            if (type_wr_ok)
                type_r <= type_wd;
            if (zoff_wr)
                zoff_r <= avs_writedata;
            if (acc & avs_read)
            begin
                case (avs_address)
                    HSZ_OFF_CTRL: avs_readdata <= {23'h0, abs_enc_r, tbl_mode_r, tbl_sel_r,
                        ctl_start_r, bus_req_r, 2'h0, mode_r};
                    HSZ_OFF_TYPE: avs_readdata <= {{24{type_r[7]}}, type_r};
                    HSZ_OFF_ZOFF: avs_readdata <= zoff_r;
                    HSZ_OFF_STAT: avs_readdata <= {26'h0, ref_sync2_r,
                        (state_r != HSZ_IDLE), refd_r};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Waitrequest drops in the answer cycle only
    assign avs_waitrequest = wait_r;

    // Reference pins in the order shown on ref_inputs
    wire [3:0] ref_pins = {enc_index, ref_cam, lim_pos, lim_neg};

    // Pin synchronisers: limits, cam and index; the homing-start input is synchronised in the run control block
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_ref_sync
            always_ff @(posedge mclk)
            begin
                if (!resetn)
                begin
                    ref_sync1_r[gi] <= 1'b0;
                    ref_sync2_r[gi] <= 1'b0;
                end
                else
                begin
                    ref_sync1_r[gi] <= ref_pins[gi];
                    ref_sync2_r[gi] <= ref_sync1_r[gi];
                end
            end
        end
    endgenerate

    // Edge history and run control
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            state_r <= HSZ_IDLE;
            hs_sync_r <= 2'h0;
            hs_prev_r <= 1'b0;
            {bus_prev_r, ctl_prev_r, tbl_prev_r, seq_prev_r} <= 4'h0;
            refd_r <= 1'b0;
            bus_run_r <= 1'b0;
            pwr_seen_r <= 1'b0;
            pos_r <= '0;
            load_r <= 1'b0;
            ferr_r <= 1'b0;
            move_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            hs_sync_r <= {hs_sync_r[0], input_homing_start_function};
            hs_prev_r <= hs_sync_r[1];
            bus_prev_r <= bus_req_r;
            ctl_prev_r <= ctl_start_r;
            tbl_prev_r <= tbl_sel_r;
            seq_prev_r <= seq_goto_ref;
            // First start after reset spends the power-up reference
            pwr_seen_r <= pwr_seen_r | start;
            // Only a run that the fieldbus bit started is cut by its release
            if (start)
                bus_run_r <= bus_rise & (mode_r == HSZ_START_OFF);
            // Completion sets; a change in the same cycle wins, as config is then stale
            if (cfg_change)
                refd_r <= 1'b0;
            else if (state_r == HSZ_LOAD)
                refd_r <= 1'b1;
            move_r <= (state_nxt == HSZ_RUN);
            load_r <= (state_r == HSZ_LOAD);
            ferr_r <= (state_r == HSZ_LOAD) & (type_r == HSZ_TYPE_SETPOS);
            if (state_r == HSZ_LOAD)
                pos_r <= is_abs ? abs_sum : POS_W'(zoff_r);
        end
    end

    assign act_pos = pos_r;
    assign act_pos_load = load_r;
    assign ferr_clear = ferr_r;
    assign move_req = move_r;
    assign referenced = refd_r;
    assign ref_inputs = ref_sync2_r[3:0];

    // Absolute type computes offset sum; zero offset gives raw position
    a_abs_sum_load: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == HSZ_LOAD && is_abs)
        |=> (act_pos == 32'($past(enc_abs_pos) + $past(zoff_r))))
        else $error("absolute load value wrong");
    a_abs_zero_raw: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == HSZ_LOAD && is_abs && zoff_r == 0) |=> act_pos == $past(enc_abs_pos))
        else $error("zero offset not raw position");
    a_setpos_ferr: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == HSZ_LOAD && type_r == HSZ_TYPE_SETPOS)
        |=> ferr_clear && act_pos_load && act_pos == $past(zoff_r))
        else $error("set-position did not clear error");
    a_auto_once: assert property (@(posedge mclk) disable iff (!resetn)
        (mode_r == HSZ_START_AUTO && refd_r && !is_abs && state_r == HSZ_IDLE)
        |=> state_r == HSZ_IDLE)
        else $error("auto start repeated");
    a_tbl_once: assert property (@(posedge mclk) disable iff (!resetn)
        (mode_r == HSZ_START_ON_FIRST_TABLE_SET && refd_r && state_r == HSZ_IDLE
        && pwr_seen_r)
        |=> state_r == HSZ_IDLE)
        else $error("table start repeated");
    a_hs_edge: assert property (@(posedge mclk) disable iff (!resetn)
        (mode_r == HSZ_START_OFF && state_r == HSZ_IDLE && hs_rise)
        |=> state_r != HSZ_IDLE)
        else $error("homing input edge missed");
    a_abs_no_move: assert property (@(posedge mclk) disable iff (!resetn)
        (start && no_move) |=> (!move_req && state_r == HSZ_LOAD))
        else $error("absolute reference moved axis");
    a_cfg_clear: assert property (@(posedge mclk) disable iff (!resetn)
        cfg_change |=> !referenced)
        else $error("referenced kept after change");
    a_type_range: assert property (@(posedge mclk) disable iff (!resetn)
        type_r >= HSZ_TYPE_MIN && type_r <= HSZ_TYPE_MAX)
        else $error("type out of range");
    a_bus_answer: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(avs_read | avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");
    a_wait_one: assert property (@(posedge mclk) disable iff (!resetn)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    // Fieldbus release and power-up reference
    a_bus_abort: assert property (@(posedge mclk) disable iff (!resetn)
        bus_abort |=> (!move_req && state_r == HSZ_IDLE))
        else $error("fieldbus release did not stop run");
    a_pwr_once: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == HSZ_IDLE && is_abs && !pwr_seen_r) |=> state_r == HSZ_LOAD)
        else $error("power-up reference missing");

    c_seq_run: cover property (@(posedge mclk) disable iff (!resetn)
        seq_rise && mode_r == HSZ_START_OFF ##[1:20] act_pos_load);
    c_auto_run: cover property (@(posedge mclk) disable iff (!resetn)
        req_auto ##[1:50] referenced);
    c_abs_run: cover property (@(posedge mclk) disable iff (!resetn)
        is_abs && state_r == HSZ_LOAD);
    c_bus_abort: cover property (@(posedge mclk) disable iff (!resetn)
        bus_abort);
    c_tbl_run: cover property (@(posedge mclk) disable iff (!resetn)
        req_tbl ##[1:50] referenced);
endmodule

// ===== sim/hsz_partner.sv
// Far-side model: motion run completion, absolute encoder and reference pins
`timescale 1ns/1ps
module hsz_partner (
    input wire logic mclk,
    input wire logic move_req,
    output logic move_done,
    output logic [31:0] enc_abs_pos,
    output logic [3:0] pins
);
    int cnt = 0;
    logic req_d = 1'b0;
    initial
    begin
        move_done = 1'b0;
        enc_abs_pos = 32'h1234_5678;
        pins = 4'h5;
    end
    // Axis moves for a random time, so slow and prompt answers both occur
    always @(posedge mclk)
    begin
        req_d <= move_req;
        move_done <= 1'b0;
        if (move_req === 1'b1 && req_d === 1'b0)
        begin
            cnt <= $urandom_range(12, 3);
            enc_abs_pos <= $urandom();
            pins <= 4'($urandom());
        end
        else if (move_req === 1'b1)
        begin
            cnt <= cnt - 1;
            move_done <= (cnt == 1);
        end
    end
endmodule

// ===== sim/tb_hsz_homing_start.sv
// Self-checking bench for the homing start and zero-set controller
`timescale 1ns/1ps
module tb_hsz_homing_start;
    import hsz_pkg::*;
    localparam logic [31:0] BUS = 32'h1 << HSZ_CTRL_BUSREQ_BIT;
    localparam logic [31:0] CST = 32'h1 << HSZ_CTRL_CTLSTART_BIT;
    localparam logic [31:0] TSEL = 32'h1 << HSZ_CTRL_TBLSEL_BIT;
    localparam logic [31:0] TMOD = 32'h1 << HSZ_CTRL_TBLMODE_BIT;
    logic mclk = 1'b0, resetn = 1'b0, rd = 1'b0, wr_s = 1'b0, pin = 1'b0, seq = 1'b0;
    logic [3:0] addr = 4'h0, pins;
    logic [31:0] wdata = 32'h0, rdata, enc, act_pos, last_pos, zv, q;
    logic wait_n, move_done, act_pos_load, ferr_clear, move_req, referenced, ferr_seen, mr_d;
    logic [3:0] ref_inputs;
    int errors = 0, samples_checked = 0, runs = 0, loads = 0, cyc = 0, exp_runs = 0;
    int exp_loads = 0, lsnap = 0;
    logic [7:0] tv [4] = '{8'h24, 8'hF8, 8'h23, 8'hF9};
    hsz_homing_start u_hsz_homing_start (.mclk(mclk), .resetn(resetn), .avs_address(addr),
        .avs_read(rd), .avs_write(wr_s), .avs_writedata(wdata), .avs_byteenable(4'hF),
        .avs_readdata(rdata), .avs_waitrequest(wait_n), .input_homing_start_function(pin),
        .seq_goto_ref(seq), .lim_neg(pins[0]), .lim_pos(pins[1]), .ref_cam(pins[2]),
        .enc_index(pins[3]), .enc_abs_pos(enc), .power_on(1'b0), .move_done(move_done),
        .act_pos(act_pos), .act_pos_load(act_pos_load), .ferr_clear(ferr_clear),
        .move_req(move_req), .referenced(referenced), .ref_inputs(ref_inputs));
    hsz_partner u_hsz_partner (.mclk(mclk), .move_req(move_req), .move_done(move_done),
        .enc_abs_pos(enc), .pins(pins));
    initial
    begin
        forever #10 mclk = ~mclk;
    end
    // Count motion starts and position loads; cut a hang short
    always @(posedge mclk)
    begin
        mr_d <= move_req;
        if (move_req === 1'b1 && mr_d === 1'b0) runs++;
        if (act_pos_load === 1'b1)
        begin
            loads++;
            last_pos = act_pos;
            ferr_seen = ferr_clear;
        end
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        if (w) wr_s <= 1'b1; else rd <= 1'b1;
        do
        begin
            @(posedge mclk);
        end while (wait_n !== 1'b0);
        q = rdata;
        wr_s <= 1'b0;
        rd <= 1'b0;
    endtask
    // Raise a bus or pin request, or pulse the sequence request; wait for the run, then drop a held request
    task automatic kick(input int src, input logic [31:0] base, input logic [31:0] b);
        int r0, l0, n;
        r0 = runs;
        l0 = loads;
        n = 0;
        if (src == 0) bus(1, HSZ_OFF_CTRL, base | b);
        else if (src == 1) @(posedge mclk) pin <= 1'b1;
        else
        begin
            @(posedge mclk) seq <= 1'b1;
            @(posedge mclk) seq <= 1'b0;
        end
        while (!((runs > r0 && move_req === 1'b0) || loads > l0) && n < 300)
        begin
            @(posedge mclk);
            n++;
        end
        repeat (6) @(posedge mclk);
        if (src == 0) bus(1, HSZ_OFF_CTRL, base);
        pin <= 1'b0;
        chk(runs, exp_runs);
        chk(n < 300, (exp_runs > r0) || (exp_loads > l0));
    endtask
    task automatic conclude();
        $display("checked %0d, wrong %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        void'($urandom(87));
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        bus(0, HSZ_OFF_TYPE, 0);
        chk(q[7:0], 8'hFF);
        bus(0, HSZ_OFF_ZOFF, 0);
        chk(q, 32'h0);
        bus(0, 4'h2, 0);
        chk(q, 32'h0);
        chk(referenced, 1'b0);
        // Out-of-range type values are refused, edge values kept
        foreach (tv[i])
        begin
            bus(1, HSZ_OFF_TYPE, 32'(tv[i]));
            bus(0, HSZ_OFF_TYPE, 0);
            chk(q[7:0], i < 2 ? 8'hFF : (i == 2 ? 8'h23 : 8'hF9));
        end
        $display("test reset and type range done");
        zv = $urandom();
        bus(1, HSZ_OFF_ZOFF, zv);
        exp_loads++;
        kick(0, 0, BUS);
        chk(loads, exp_loads);
        chk(last_pos, zv);
        chk(ferr_seen, 1'b1);
        $display("test set position done");
        bus(1, HSZ_OFF_TYPE, 32'hFB);
        // Zero adjust: offset 0, repeat, then enter the correction
        for (int i = 0; i < 3; i++)
        begin
            zv = (i < 2) ? 32'h0 : 32'h0 - enc;
            bus(1, HSZ_OFF_ZOFF, zv);
            exp_loads++;
            kick(0, 0, BUS);
            chk(loads, exp_loads);
            chk(last_pos, i < 2 ? enc : 32'h0);
        end
        $display("test absolute encoder done");
        // Second reset: a type -5 setting references once with no request
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk(referenced, 1'b0);
        bus(1, HSZ_OFF_TYPE, 32'hFB);
        repeat (8) @(posedge mclk);
        exp_loads++;
        chk(loads, exp_loads);
        chk(last_pos, enc);
        chk(referenced, 1'b1);
        $display("test power-up reference done");
        bus(1, HSZ_OFF_TYPE, 32'h1);
        @(posedge mclk);
        chk(referenced, 1'b0);
        exp_runs++;
        kick(1, 0, 0);
        chk(ref_inputs, pins);
        chk(referenced, 1'b1);
        exp_runs++;
        kick(2, 0, 0);
        exp_runs++;
        kick(2, 0, 0);
        // Releasing the fieldbus bit cuts the run that it started
        lsnap = loads;
        exp_runs++;
        bus(1, HSZ_OFF_CTRL, BUS);
        bus(1, HSZ_OFF_CTRL, 0);
        repeat (20) @(posedge mclk);
        chk(runs, exp_runs);
        chk(loads, lsnap);
        chk(move_req, 1'b0);
        $display("test request sources done");
        bus(1, HSZ_OFF_CTRL, 32'h1);
        @(posedge mclk);
        chk(referenced, 1'b0);
        exp_runs++;
        kick(0, 32'h1, CST);
        kick(0, 32'h1, CST);
        bus(1, HSZ_OFF_TYPE, 32'h2);
        exp_runs++;
        kick(0, 32'h1, CST);
        exp_runs++;
        kick(0, 32'h2 | TMOD, TSEL);
        kick(0, 32'h2 | TMOD, TSEL);
        $display("test automatic starts done");
        conclude();
    end
endmodule
